// ---- excc_regs.svh ----
// Register map, field positions, reset values and constants for the xstate check block.
// Assumes inclusion by bare name; definitions only.
`ifndef EXCC_REGS_SVH
`define EXCC_REGS_SVH

// ============================================================
// Register offsets (byte addresses, one 32-bit word each)
`define EXCC_CTRL_OFF        8'h00
`define EXCC_CMD_OFF         8'h04
`define EXCC_STATUS_OFF      8'h08
`define EXCC_MASK_LO_OFF     8'h0c
`define EXCC_MASK_HI_OFF     8'h10
`define EXCC_XCR_LO_OFF      8'h14
`define EXCC_XCR_HI_OFF      8'h18
`define EXCC_FRAME_OFF       8'h1c
`define EXCC_MISC_OFF        8'h20
`define EXCC_REQSZ_OFF       8'h24
`define EXCC_SAVED_LO_OFF    8'h28
`define EXCC_SAVED_HI_OFF    8'h2c
`define EXCC_KEYSEL_OFF      8'h30
`define EXCC_KEY_LO_OFF      8'h34
`define EXCC_KEY_HI_OFF      8'h38
`define EXCC_KEYMISC_OFF     8'h3c
`define EXCC_MISC_SELECT_MASK_OFF    8'h40
`define EXCC_SPV_LO_OFF      8'h44
`define EXCC_SPV_HI_OFF      8'h48
`define EXCC_RSTCHK_OFF      8'h4c
`define EXCC_XBASE_OFF       8'h50
`define EXCC_MCOPY_OFF       8'h54

// ============================================================
// Control register fields
`define EXCC_CTRL_FXSR_BIT   0
`define EXCC_CTRL_XSAVE_BIT  1
`define EXCC_CTRL_MODE64_BIT 2

// Status register fields
`define EXCC_ST_FAULT_BIT    0
`define EXCC_ST_INSIDE_BIT   1
`define EXCC_ST_BUSY_BIT     2
`define EXCC_ST_MOD_BIT      3

// Resume data check bits (written by software over the bus)
`define EXCC_RC_HDR_BIT      0
`define EXCC_RC_SIMD_BIT     1

// ============================================================
// Values
`define EXCC_MASK_BASE       64'h0000_0000_0000_0003
`define EXCC_LEGACY_SIZE     32'h0000_0240
`define EXCC_MASK_COPY_OFF   32'h0000_0200
`define EXCC_XREGION_OFF     32'h0000_0000
`define EXCC_PAGE_SHIFT      12
`define EXCC_TOP_BIT         63
`define EXCC_FIRST_COMP      2
`define EXCC_RST_MASK        64'h0000_0000_0000_0003

`endif

// ---- excc_pkg.sv ----
// Types shared by the xstate check block and its size calculator.
// Assumes the includer also sees excc_regs.svh for numeric constants.
package excc_pkg;

	// ============================================================
	// Operation codes written to the command register.
	typedef enum logic [2:0] {
		EXCC_OP_NONE   = 3'h0,
		EXCC_OP_CREATE = 3'h1,
		EXCC_OP_ENTER  = 3'h2,
		EXCC_OP_RESUME = 3'h3,
		EXCC_OP_AEX    = 3'h4,
		EXCC_OP_EXIT   = 3'h5
	} excc_op_t;

	// Sequencer states, one-hot.
	typedef enum logic [2:0] {
		EXCC_S_IDLE = 3'b001,
		EXCC_S_SIZE = 3'b010,
		EXCC_S_DONE = 3'b100
	} excc_state_t;

	// Request to the component size walker.
	typedef struct packed {
		logic        start;
		logic [63:0] mask;
	} excc_size_req_t;

	// Answer from the component size walker.
	typedef struct packed {
		logic        done;
		logic [31:0] size;
	} excc_size_rsp_t;

endpackage

// ---- excc_size_walk.sv ----
// Walks feature mask bits 2..63 and accumulates the required extended region size.
// Assumes component offset and size tables come in as flat inputs from the core.
`timescale 1ns/10ps
`include "excc_regs.svh"
module excc_size_walk #(
	parameter int NCOMP = 64
) (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   arst_n,
	input  wire logic                   clk_en,
	// Request and answer
	input  wire excc_pkg::excc_size_req_t req,
	output excc_pkg::excc_size_rsp_t      rsp,
	// Component layout tables
	input  wire logic [NCOMP*32-1:0]    comp_off,
	input  wire logic [NCOMP*32-1:0]    comp_size
);
	logic [5:0]  idx_q;
	logic        run_q;
	logic [31:0] end_q;
	logic [31:0] off_w;
	logic [31:0] sz_w;

	assign off_w = comp_off[idx_q*32 +: 32];
	assign sz_w  = comp_size[idx_q*32 +: 32];

	// ============================================================
	// One mask bit per cycle; 62 cycles per walk trades speed for one adder.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			idx_q <= 6'h00;
			run_q <= 1'b0;
			end_q <= 32'h0000_0000;
			rsp   <= '0;
		end else if (clk_en) begin
			rsp.done <= 1'b0;
			if (req.start) begin
				idx_q <= 6'(`EXCC_FIRST_COMP);
				run_q <= 1'b1;
				end_q <= `EXCC_LEGACY_SIZE; // [RQ6]
			end else if (run_q) begin
				// A component only extends the end when it lies at or beyond it.
				if (req.mask[idx_q] && off_w >= end_q) begin
					end_q <= off_w + sz_w; // [RQ6]
				end
				if (idx_q == 6'(`EXCC_TOP_BIT)) begin
					run_q    <= 1'b0;
					rsp.done <= 1'b1;
					rsp.size <= (req.mask[idx_q] && off_w >= end_q) ? off_w + sz_w : end_q;
				end else begin
					idx_q <= idx_q + 6'h01;
				end
			end
		end
	end
endmodule

// ---- excc_core.sv ----
// Extended state configuration checker and control register swapper for enclave ops.
// Assumes a classic Wishbone master on ref_clk and a core that supplies the
// component layout tables and acts on the save/restore/synthesis strobes.
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
`include "excc_regs.svh"

// Functional notes
// RQ1: Create faults unless mask low bits 3.
// RQ2: No xsave: faults on high bits, zero frame.
// RQ3: Xsave: fault illegal mask, bit63, small frame.
// RQ4: Frame pages cover all regions, non-compacted.
// RQ5: No xsave: region 576, mask copy 512.
// RQ6: Size walk from 576 over mask components.
// RQ7: Extended region starts at frame offset zero.
// RQ8: Misc region sits before register region.
// RQ9: Enter faults on fxsave off, mask checks.
// RQ10: Resume applies the same entry checks.
// RQ11: Enter saves control reg, loads mask.
// RQ12: Resume saves control reg, loads mask.
// RQ13: Async exit saves state with mask selector.
// RQ14: Present bits zero where mask bit zero.
// RQ15: Async exit restores control reg afterwards.
// RQ16: Async exit synthesizes enabled component state.
// RQ17: Resume restores with mask as selector.
// RQ18: Resume faults on bad saved data.
// RQ19: Resume marks all state modified.
// RQ20: Report carries mask and misc selection.
// RQ21: Key uses only selected mask bits.
// RQ22: Software sets mask 3 or control subset.
// RQ23: Sync exit restores control reg, no checks.
// RQ24: Static input selects xsave check path.
module excc_core #(
	parameter int NCOMP = 64
) (
	// Clock, reset and enable
	input  wire logic                ref_clk,
	input  wire logic                arst_n,
	input  wire logic                clk_en,
	// Static configuration
	input  wire logic                xsave_supported,
	input  wire logic [63:0]         xcr_legal_mask,
	// Component layout tables
	input  wire logic [NCOMP*32-1:0] comp_off,
	input  wire logic [NCOMP*32-1:0] comp_size,
	// Wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,
	output logic                     wb_err_o,
	// Strobes to the state datapath
	output logic                     gp_fault,
	output logic                     save_strobe,
	output logic                     restore_strobe,
	output logic                     synth_strobe,
	output logic                     save_wide,
	output logic [63:0]              ext_sel_mask,
	output logic [63:0]              extended_control_reg
);
	// ============================================================
	// Registers
	logic [2:0]  ctrl_q;
	logic [63:0] mask_q;
	logic [63:0] xcr_q;
	logic [63:0] saved_q;
	logic [31:0] frame_q;
	logic [31:0] misc_q;
	logic [31:0] reqsz_q;
	logic [63:0] keysel_q;
	logic [31:0] misc_select_mask_q;
	logic [63:0] spv_q;
	logic [1:0]  rstchk_q;
	logic        fault_q;
	logic        inside_q;
	logic        modified_q;
	excc_pkg::excc_op_t    op_q;
	excc_pkg::excc_state_t st_q;
	excc_pkg::excc_size_req_t sreq;
	excc_pkg::excc_size_rsp_t srsp;

	logic        wb_hit;
	logic        wr;
	logic        cmd_wr;
	logic        mapped;
	logic [31:0] rd_d;

	// Byte-enable merge for a 32-bit word.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Entry checks shared by enter and resume.
	function automatic logic entry_bad(input logic [2:0] c, input logic [63:0] m,
		input logic [63:0] x, input logic xs);
		logic b;
		b = !c[`EXCC_CTRL_FXSR_BIT]; // [RQ9] [RQ10]
		if (xs) begin
			if (!c[`EXCC_CTRL_XSAVE_BIT] && m != `EXCC_MASK_BASE) begin
				b = 1'b1;
			end
			if ((m & x) != m) begin
				b = 1'b1;
			end
		end
		return b;
	endfunction

	// ============================================================
	// Wishbone decode; ack one cycle after strobe, dropped the cycle after.
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wr     = wb_hit && wb_we_i && mapped;
	assign cmd_wr = wr && wb_adr_i == `EXCC_CMD_OFF && st_q == excc_pkg::EXCC_S_IDLE;

	always_comb begin
		mapped = 1'b1;
		rd_d   = 32'h0000_0000;
		unique case (wb_adr_i)
			`EXCC_CTRL_OFF:     rd_d = {29'h0, ctrl_q};
			`EXCC_CMD_OFF:      rd_d = {29'h0, op_q};
			`EXCC_STATUS_OFF:   rd_d = {28'h0, modified_q, st_q != excc_pkg::EXCC_S_IDLE,
				inside_q, fault_q};
			`EXCC_MASK_LO_OFF:  rd_d = mask_q[31:0]; // [RQ20]
			`EXCC_MASK_HI_OFF:  rd_d = mask_q[63:32];
			`EXCC_XCR_LO_OFF:   rd_d = xcr_q[31:0];
			`EXCC_XCR_HI_OFF:   rd_d = xcr_q[63:32];
			`EXCC_FRAME_OFF:    rd_d = frame_q;
			`EXCC_MISC_OFF:     rd_d = misc_q; // [RQ20]
			`EXCC_REQSZ_OFF:    rd_d = reqsz_q;
			`EXCC_SAVED_LO_OFF: rd_d = saved_q[31:0];
			`EXCC_SAVED_HI_OFF: rd_d = saved_q[63:32];
			`EXCC_KEYSEL_OFF:   rd_d = keysel_q[31:0];
			// Key material holds only selected mask and misc bits.
			`EXCC_KEY_LO_OFF:   rd_d = mask_q[31:0] & keysel_q[31:0]; // [RQ21]
			`EXCC_KEY_HI_OFF:   rd_d = mask_q[63:32] & keysel_q[63:32];
			`EXCC_KEYMISC_OFF:  rd_d = misc_q & misc_select_mask_q; // [RQ21]
			`EXCC_MISC_SELECT_MASK_OFF: rd_d = misc_select_mask_q;
			`EXCC_SPV_LO_OFF:   rd_d = spv_q[31:0];
			`EXCC_SPV_HI_OFF:   rd_d = spv_q[63:32];
			`EXCC_RSTCHK_OFF:   rd_d = {30'h0, rstchk_q};
			`EXCC_XBASE_OFF:    rd_d = `EXCC_XREGION_OFF; // [RQ7]
			// The mask copy slot only exists in the reduced 576-byte layout.
			`EXCC_MCOPY_OFF:    rd_d = xsave_supported ? 32'h0000_0000 : `EXCC_MASK_COPY_OFF; // [RQ5]
			default:            mapped = 1'b0;
		endcase
	end

	// Bus answer registers; unmapped addresses get err instead of ack.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (clk_en) begin
			wb_ack_o <= wb_hit && mapped;
			wb_err_o <= wb_hit && !mapped;
			wb_dat_o <= rd_d;
		end
	end

	// ============================================================
	// Software-written configuration.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q     <= 3'h0;
			frame_q    <= 32'h0000_0000;
			misc_q     <= 32'h0000_0000;
			keysel_q   <= 64'h0;
			misc_select_mask_q <= 32'h0000_0000;
			rstchk_q   <= 2'h0;
			mask_q     <= `EXCC_RST_MASK;
		end else if (clk_en && wr) begin
			unique case (wb_adr_i)
				`EXCC_CTRL_OFF:     ctrl_q <= 3'(merge({29'h0, ctrl_q}, wb_dat_i, wb_sel_i));
				`EXCC_MASK_LO_OFF:  mask_q[31:0] <= merge(mask_q[31:0], wb_dat_i, wb_sel_i);
				`EXCC_MASK_HI_OFF:  mask_q[63:32] <= merge(mask_q[63:32], wb_dat_i, wb_sel_i);
				`EXCC_FRAME_OFF:    frame_q <= merge(frame_q, wb_dat_i, wb_sel_i);
				`EXCC_MISC_OFF:     misc_q <= merge(misc_q, wb_dat_i, wb_sel_i);
				`EXCC_KEYSEL_OFF:   keysel_q[31:0] <= merge(keysel_q[31:0], wb_dat_i, wb_sel_i);
				`EXCC_MISC_SELECT_MASK_OFF: misc_select_mask_q <= merge(misc_select_mask_q, wb_dat_i, wb_sel_i);
				`EXCC_RSTCHK_OFF:   rstchk_q <= 2'(merge({30'h0, rstchk_q}, wb_dat_i, wb_sel_i));
				default:            ;
			endcase
		end
	end

	// Saved present vector: software stages restore data, and an async-exit save
	// clears every bit outside the mask. The save wins over a same-cycle write.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			spv_q <= 64'h0;
		end else if (clk_en) begin
			if (save_strobe) begin
				spv_q <= spv_q & mask_q; // [RQ14]
			end else if (wr && wb_adr_i == `EXCC_SPV_LO_OFF) begin
				spv_q[31:0] <= merge(spv_q[31:0], wb_dat_i, wb_sel_i);
			end else if (wr && wb_adr_i == `EXCC_SPV_HI_OFF) begin
				spv_q[63:32] <= merge(spv_q[63:32], wb_dat_i, wb_sel_i);
			end
		end
	end

	// ============================================================
	// Size walker for the full path.
	assign sreq.mask  = mask_q;
	assign sreq.start = cmd_wr && xsave_supported &&
		excc_pkg::excc_op_t'(wb_dat_i[2:0]) == excc_pkg::EXCC_OP_CREATE;

	excc_size_walk #(.NCOMP(NCOMP)) u_walk (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.clk_en    (clk_en),
		.req       (sreq),
		.rsp       (srsp),
		.comp_off  (comp_off),
		.comp_size (comp_size)
	);

	// ============================================================
	// Operation sequencer and control register swap.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q           <= excc_pkg::EXCC_S_IDLE;
			op_q           <= excc_pkg::EXCC_OP_NONE;
			fault_q        <= 1'b0;
			inside_q       <= 1'b0;
			modified_q     <= 1'b0;
			xcr_q          <= `EXCC_RST_MASK;
			saved_q        <= `EXCC_RST_MASK;
			reqsz_q        <= 32'h0000_0000;
			gp_fault       <= 1'b0;
			save_strobe    <= 1'b0;
			restore_strobe <= 1'b0;
			synth_strobe   <= 1'b0;
		end else if (clk_en) begin
			gp_fault       <= 1'b0;
			save_strobe    <= 1'b0;
			restore_strobe <= 1'b0;
			synth_strobe   <= 1'b0;
			// Outside an enclave software may load the control register.
			if (wr && !inside_q && wb_adr_i == `EXCC_XCR_LO_OFF) begin
				xcr_q[31:0] <= merge(xcr_q[31:0], wb_dat_i, wb_sel_i);
			end
			if (wr && !inside_q && wb_adr_i == `EXCC_XCR_HI_OFF) begin
				xcr_q[63:32] <= merge(xcr_q[63:32], wb_dat_i, wb_sel_i);
			end
			unique case (st_q)
				excc_pkg::EXCC_S_IDLE: begin
					if (cmd_wr) begin
						op_q    <= excc_pkg::excc_op_t'(wb_dat_i[2:0]);
						fault_q <= 1'b0;
						st_q    <= excc_pkg::EXCC_S_DONE;
						if (excc_pkg::excc_op_t'(wb_dat_i[2:0]) == excc_pkg::EXCC_OP_CREATE
							&& xsave_supported) begin
							st_q <= excc_pkg::EXCC_S_SIZE; // [RQ24]
						end
					end
				end
				excc_pkg::EXCC_S_SIZE: begin
					if (srsp.done) begin
						reqsz_q <= srsp.size;
						st_q    <= excc_pkg::EXCC_S_DONE;
					end
				end
				excc_pkg::EXCC_S_DONE: begin
					st_q <= excc_pkg::EXCC_S_IDLE;
					unique case (op_q)
						excc_pkg::EXCC_OP_CREATE: begin
							// Frame bytes compare at 44 bits so a huge page count cannot wrap.
							if (mask_q[1:0] != 2'(`EXCC_MASK_BASE) ||
								(!xsave_supported && (mask_q[63:2] != 62'h0 ||
								frame_q == 32'h0000_0000)) || // [RQ1] [RQ2]
								(xsave_supported && (mask_q[`EXCC_TOP_BIT] ||
								(mask_q & ~xcr_legal_mask) != 64'h0 ||
								({12'h000, frame_q} << `EXCC_PAGE_SHIFT) <
								{12'h000, reqsz_q}))) begin // [RQ3] [RQ4]
								fault_q  <= 1'b1;
								gp_fault <= 1'b1;
							end
							if (!xsave_supported) begin
								reqsz_q <= `EXCC_LEGACY_SIZE; // [RQ5]
							end
						end
						excc_pkg::EXCC_OP_ENTER, excc_pkg::EXCC_OP_RESUME: begin
							if (inside_q || entry_bad(ctrl_q, mask_q, xcr_q, xsave_supported) ||
								(op_q == excc_pkg::EXCC_OP_RESUME && ((spv_q & ~mask_q) != 64'h0
								|| rstchk_q != 2'h0))) begin // [RQ18]
								fault_q  <= 1'b1;
								gp_fault <= 1'b1;
							end else begin
								saved_q  <= xcr_q; // [RQ11] [RQ12]
								xcr_q    <= mask_q;
								inside_q <= 1'b1;
								if (op_q == excc_pkg::EXCC_OP_RESUME) begin
									restore_strobe <= 1'b1; // [RQ17]
									modified_q     <= 1'b1; // [RQ19]
								end
							end
						end
						excc_pkg::EXCC_OP_AEX: begin
							if (inside_q) begin
								save_strobe  <= 1'b1; // [RQ13] [RQ14]
								synth_strobe <= 1'b1; // [RQ16]
								xcr_q        <= saved_q; // [RQ15]
								inside_q     <= 1'b0;
								modified_q   <= 1'b0;
							end
						end
						excc_pkg::EXCC_OP_EXIT: begin
							if (inside_q) begin
								xcr_q      <= saved_q; // [RQ23]
								inside_q   <= 1'b0;
								modified_q <= 1'b0;
							end
						end
						default: ;
					endcase
				end
				default: st_q <= excc_pkg::EXCC_S_IDLE;
			endcase
		end
	end

	// Save selector is the mask; datapath writes present bits masked by it.
	assign ext_sel_mask         = mask_q; // [RQ14] [RQ17]
	assign save_wide            = ctrl_q[`EXCC_CTRL_MODE64_BIT]; // [RQ13]
	assign extended_control_reg = xcr_q;
endmodule

// ---- excc_core_asserts.sv ----
// Port-level assertions for the xstate check block.
// Assumes a bind into excc_core with clk_en held high by the bench.
`timescale 1ns/10ps
`include "excc_regs.svh"
module excc_core_asserts (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        arst_n,
	// Bus handshake
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	// Result strobes and state
	input wire logic        gp_fault,
	input wire logic        save_strobe,
	input wire logic        restore_strobe,
	input wire logic        synth_strobe,
	input wire logic [63:0] ext_sel_mask,
	input wire logic [63:0] extended_control_reg
);
	// ============================================================
	// Setup
	// One clock domain, so clocking and reset are declared once.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	// ============================================================
	// Bus and reset
	// A taken request is answered next cycle by exactly one of ack or err.
	a_bus_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o)
		|=> (wb_ack_o ^ wb_err_o)) else $error("request not answered");
	// No answer may appear without a request in the cycle before.
	a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
		else $error("answer without request");
	// The control register leaves reset holding the base mask.
	a_xcr_reset_val: assert property ($rose(arst_n) |-> extended_control_reg == `EXCC_RST_MASK)
		else $error("control register reset value wrong");

	// ============================================================
	// Operations
	// A faulting operation must leave the control register alone.
	a_fault_keeps_xcr: assert property (gp_fault |-> $stable(extended_control_reg) ##1
		$stable(extended_control_reg)) else $error("control register moved on fault");
	// A fault suppresses every state datapath strobe.
	a_fault_no_result: assert property (gp_fault |-> !save_strobe && !restore_strobe
		&& !synth_strobe) else $error("strobe issued with fault");
	// Resume swaps the request mask into the control register.
	a_resume_loads: assert property (restore_strobe |-> ##[0:2]
		(extended_control_reg == ext_sel_mask)) else $error("resume did not load mask");
	// Saving on async exit is followed by synthesis of fresh state.
	a_save_synth: assert property (save_strobe |-> ##[0:3] synth_strobe)
		else $error("no synthesis after save");
	// Save and restore never overlap.
	a_save_xor_rest: assert property (!(save_strobe && restore_strobe))
		else $error("save and restore together");

	// Main scenarios reached.
	c_fault: cover property (gp_fault);
	c_save: cover property (save_strobe);
	c_restore: cover property (restore_strobe);
	c_err: cover property (wb_err_o);
endmodule

bind excc_core excc_core_asserts excc_core_asserts_inst (
	.ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .gp_fault(gp_fault),
	.save_strobe(save_strobe), .restore_strobe(restore_strobe),
	.synth_strobe(synth_strobe), .ext_sel_mask(ext_sel_mask),
	.extended_control_reg(extended_control_reg));

// ---- enclave_xstate_config_check_bench.sv ----
// Self-checking bench for the xstate check block over classic Wishbone.
// Assumes the register offsets of excc_regs.svh and the command encodings of excc_pkg.
`timescale 1ns/10ps
`include "excc_regs.svh"
module enclave_xstate_config_check_bench;
	logic              ref_clk, arst_n, clk_en, xsave_supported;
	logic [63:0]       xcr_legal_mask;
	logic [2047:0]     comp_off, comp_size;
	logic              wb_cyc_i, wb_stb_i, wb_we_i;
	logic [7:0]        wb_adr_i;
	logic [3:0]        wb_sel_i;
	logic [31:0]       wb_dat_i, wb_dat_o, q, st;
	logic              wb_ack_o, wb_err_o, gp_fault, save_strobe, restore_strobe;
	logic              synth_strobe, save_wide, berr;
	logic [63:0]       ext_sel_mask, extended_control_reg, q64;
	int                errors, cmp_count, cycles, n_save, n_synth, n_rest;
	// Create table: xsave path, mask, frame pages, fault, required size.
	logic [9:0]  t_xs  = 10'b1111110000;
	logic [9:0]  t_flt = 10'b0111100111;
	logic [63:0] t_mask [10] = '{64'h3, 64'h1, 64'h7, 64'h3, 64'h7, 64'hf,
		64'h8000_0000_0000_0007, 64'h6, 64'h17, 64'h17};
	logic [31:0] t_frm [10] = '{32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1,
		32'h1, 32'h2};
	logic [31:0] t_sz [10] = '{32'h0, 32'h0, 32'h0, 32'h240, 32'h340, 32'h0, 32'h0, 32'h0,
		32'h0, 32'h1388};
	// Refused entry cases: fxsave off, xsave off with wide mask, mask not in control.
	logic [31:0] f_ctrl [3] = '{32'h6, 32'h5, 32'h7};
	logic [63:0] f_mask [3] = '{64'h3, 64'h7, 64'h17};

	excc_core #(.NCOMP(64)) excc_core_inst (
		.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
		.xsave_supported(xsave_supported), .xcr_legal_mask(xcr_legal_mask),
		.comp_off(comp_off), .comp_size(comp_size), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.gp_fault(gp_fault), .save_strobe(save_strobe), .restore_strobe(restore_strobe),
		.synth_strobe(synth_strobe), .save_wide(save_wide), .ext_sel_mask(ext_sel_mask),
		.extended_control_reg(extended_control_reg));

	// ============================================================
	// Clock, strobe counters and hang guard
	// Free-running 250 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Strobes are one-cycle pulses, so each edge that sees one counts one.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (save_strobe === 1'b1) n_save <= n_save + 1;
		if (synth_strobe === 1'b1) n_synth <= n_synth + 1;
		if (restore_strobe === 1'b1) n_rest <= n_rest + 1;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end

	// ============================================================
	// Tasks
	task automatic chk(input logic [63:0] g, input logic [63:0] x, input string m);
		cmp_count++;
		if (g !== x) begin
			errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, g, x);
		end
	endtask
	// Classic cycle: hold everything until ack or err is sampled, then release.
	task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
		if (n >= 50) chk(1'b0, 1'b1, "bus timeout");
		q = wb_dat_o;
		berr = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(a, 1'b0, 32'h0);
	endtask
	task automatic wr64(input logic [7:0] a, input logic [63:0] d);
		wr(a, d[31:0]);
		wr(a + 8'h04, d[63:32]);
	endtask
	task automatic rd64(input logic [7:0] a);
		rd(a);
		q64[31:0] = q;
		rd(a + 8'h04);
		q64[63:32] = q;
	endtask
	// Issue a command, poll busy away, then compare the fault flag.
	task automatic op(input logic [2:0] c, input logic f);
		int n;
		n = 0;
		wr(`EXCC_CMD_OFF, {29'h0, c});
		do begin
			rd(`EXCC_STATUS_OFF);
			st = q;
			n++;
		end while (st[2] !== 1'b0 && n < 100);
		chk(st[2], 1'b0, "busy cleared");
		chk(st[0], f, "fault flag");
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ============================================================
	// Main sequence
	initial begin
		{arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		{errors, cmp_count, cycles, n_save, n_synth, n_rest} = '0;
		{clk_en, wb_sel_i, xsave_supported} = {1'b1, 4'hf, 1'b0};
		xcr_legal_mask = 64'h8000_0000_0000_0017;
		comp_off = '0;
		comp_size = '0;
		comp_off[64+:32] = 32'h240;
		comp_size[64+:32] = 32'h100;
		comp_off[128+:32] = 32'h3e8;
		comp_size[128+:32] = 32'hfa0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		chk(extended_control_reg, 64'h3, "control reset");
		rd64(`EXCC_MASK_LO_OFF);
		chk(q64, 64'h3, "mask reset");
		rd(8'h80);
		chk(berr, 1'b1, "unmapped");
		rd(`EXCC_XBASE_OFF);
		chk(q, 32'h0, "region base");
		rd(`EXCC_MCOPY_OFF);
		chk(q, 32'h200, "mask copy offset");
		$display("test reset done");
		for (int i = 0; i < 10; i++) begin
			xsave_supported <= t_xs[i];
			wr64(`EXCC_MASK_LO_OFF, t_mask[i]);
			wr(`EXCC_FRAME_OFF, t_frm[i]);
			op(excc_pkg::EXCC_OP_CREATE, t_flt[i]);
			rd(`EXCC_REQSZ_OFF);
			if (!t_flt[i]) chk(q, t_sz[i], "required size");
		end
		$display("test create done");
		wr64(`EXCC_XCR_LO_OFF, 64'h7);
		for (int k = 0; k < 6; k++) begin
			wr(`EXCC_CTRL_OFF, f_ctrl[k % 3]);
			wr64(`EXCC_MASK_LO_OFF, f_mask[k % 3]);
			op(k < 3 ? excc_pkg::EXCC_OP_ENTER : excc_pkg::EXCC_OP_RESUME, 1'b1);
		end
		wr(`EXCC_CTRL_OFF, 32'h7);
		wr64(`EXCC_MASK_LO_OFF, 64'h3);
		op(excc_pkg::EXCC_OP_ENTER, 1'b0);
		chk(extended_control_reg, 64'h3, "enter load");
		rd64(`EXCC_SAVED_LO_OFF);
		chk(q64, 64'h7, "saved control");
		op(excc_pkg::EXCC_OP_EXIT, 1'b0);
		chk(extended_control_reg, 64'h7, "exit restore");
		chk(n_save + n_synth, 0, "exit synth");
		$display("test enter done");
		op(excc_pkg::EXCC_OP_ENTER, 1'b0);
		wr64(`EXCC_SPV_LO_OFF, 64'h1f);
		op(excc_pkg::EXCC_OP_AEX, 1'b0);
		chk(n_save, 1, "save count");
		chk(n_synth, 1, "synth count");
		chk(save_wide, 1'b1, "save wide");
		chk(ext_sel_mask, 64'h3, "save selector");
		chk(extended_control_reg, 64'h7, "aex restore");
		rd64(`EXCC_SPV_LO_OFF);
		chk(q64, 64'h3, "present bits");
		op(excc_pkg::EXCC_OP_RESUME, 1'b0);
		chk(n_rest, 1, "restore count");
		chk(extended_control_reg, 64'h3, "resume load");
		chk(st[3], 1'b1, "modified");
		op(excc_pkg::EXCC_OP_AEX, 1'b0);
		wr(`EXCC_RSTCHK_OFF, 32'h1);
		op(excc_pkg::EXCC_OP_RESUME, 1'b1);
		wr(`EXCC_CTRL_OFF, 32'h1);
		wr(`EXCC_RSTCHK_OFF, 32'h2);
		op(excc_pkg::EXCC_OP_RESUME, 1'b1);
		chk(n_rest, 1, "no faulty restore");
		wr(`EXCC_RSTCHK_OFF, 32'h0);
		wr(`EXCC_SPV_LO_OFF, 32'h4);
		op(excc_pkg::EXCC_OP_RESUME, 1'b1);
		wr(`EXCC_SPV_LO_OFF, 32'h0);
		op(excc_pkg::EXCC_OP_RESUME, 1'b0);
		op(excc_pkg::EXCC_OP_EXIT, 1'b0);
		chk(extended_control_reg, 64'h7, "exit after resume");
		$display("test async done");
		wr(`EXCC_KEYSEL_OFF, 32'h1);
		wr(`EXCC_MISC_OFF, 32'hff);
		wr(`EXCC_MISC_SELECT_MASK_OFF, 32'h0f);
		rd(`EXCC_KEY_LO_OFF);
		chk(q, 32'h1, "key mask");
		rd(`EXCC_KEYMISC_OFF);
		chk(q, 32'h0f, "key misc");
		rd(`EXCC_MISC_OFF);
		chk(q, 32'hff, "report misc");
		$display("test key done");
		// Mid-run reset while the control register holds 7 must bring back 3.
		arst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		chk(extended_control_reg, 64'h3, "control after reset");
		rd(`EXCC_STATUS_OFF);
		chk(q, 32'h0, "status after reset");
		$display("test reset again done");
		results();
	end
endmodule
